// [rtl/prox_port_defines.vh]
// Register map, bus address, field positions and timing for the proximity sensor host port.
`ifndef PROX_PORT_DEFINES_VH
`define PROX_PORT_DEFINES_VH
`define TARGET_ADDR        7'h13
`define REG_FIRST          8'h80
`define REG_LAST           8'h90
`define REG_COMMAND        8'h80
`define REG_PRODUCT_ID     8'h81
`define REG_RESULT_HIGH    8'h87
`define REG_RESULT_LOW     8'h88
`define CMD_SELF_TIMED     0
`define CMD_PERIODIC       1
`define CMD_SINGLE_SHOT    3
`define CMD_RESULT_READY   5
`define CMD_CONFIG_LOCK    7
`define CMD_RESET          8'h00
`define GEN_RESET          8'h00
`define RESULT_RESET       16'h0000
`define CLK_PERIOD_NS      10
`define MEAS_PERIOD_NS     4000000
`define MEAS_PERIOD_CYCLES (`MEAS_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// [rtl/proximity_sensor_host_port.v]
// I2C target port, register file and measurement command logic of the proximity sensor.
//
// Functional notes
// - Seventeen byte registers at 80h to 90h.
// - Answer only target address 13h.
// - Address LSB selects write or read.
// - Write: ack address, register, data byte.
// - Read: set pointer, restart, return byte.
// - Work at standard, fast, high-speed rates.
// - Command bit 7 reads as one.
// - Result-ready bit 5 set on new result.
// - Reading 87h or 88h clears result-ready.
// - Self-timed enable starts oscillator; sequencer also needs periodic.
// - Self-timed measures only with periodic enable.
// - Single shot ignored while self-timed enabled.
// - Interrupt pin is open drain.
// - Result high byte 87h, low 88h.
`timescale 1ns/1ps
`include "prox_port_defines.vh"

module proximity_sensor_host_port #(
   parameter [31:0] MEAS_PERIOD = `MEAS_PERIOD_CYCLES,
   // Arbitrary identification value, not taken from any product.
   parameter [7:0]  PRODUCT_ID  = 8'h5a
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        sclIn,
   input  wire        sdaIn,
   output wire        sdaOut,
   output reg         sdaOe,
   output wire        intOut,
   output wire        intOe,
   output reg         measStart,
   input  wire        measDone,
   input  wire [15:0] measData,
   output wire        lowPowerOscEn
);

   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_ADDR   = 3'h1;
   localparam [2:0] ST_ACK    = 3'h2;
   localparam [2:0] ST_RXREG  = 3'h3;
   localparam [2:0] ST_RXDATA = 3'h4;
   localparam [2:0] ST_TX     = 3'h5;
   localparam [2:0] ST_TXACK  = 3'h6;

   reg  [1:0]  sclSync;
   reg  [1:0]  sdaSync;
   reg         sclPrev;
   reg         sdaPrev;
   reg  [2:0]  state_reg;
   reg  [2:0]  afterAck_reg;
   reg  [3:0]  bitCnt_reg;
   reg  [7:0]  shift_reg;
   reg  [7:0]  tx_reg;
   reg  [7:0]  ptr_reg;
   reg         nack_reg;
   reg         selfTimed_reg;
   reg         periodic_reg;
   reg         singleShot_reg;
   reg         ready_reg;
   reg         busy_reg;
   reg         shotPending_reg;
   reg  [15:0] result_reg;
   reg  [31:0] timer_reg;
   reg  [7:0]  genReg [0:16];
   reg         wrStrobe;
   reg         rdClear;
   reg  [7:0]  wrData;
   reg  [7:0]  wrAddr;
   integer     i;

   wire scl = sclSync[1];
   wire sda = sdaSync[1];
   wire sclRise = scl & ~sclPrev;
   wire sclFall = ~scl & sclPrev;
   wire startCond = scl & sclPrev & sdaPrev & ~sda;
   wire stopCond = scl & sclPrev & ~sdaPrev & sda;

   wire [7:0] cmdView = {1'b1, 1'b0, ready_reg, 1'b0, singleShot_reg, 1'b0,
                         periodic_reg, selfTimed_reg};

   function inRange;
      input [7:0] a;
      begin
         inRange = (a >= `REG_FIRST) && (a <= `REG_LAST);
      end
   endfunction

   function [7:0] regRead;
      input [7:0] a;
      begin
         if (a == `REG_COMMAND)
            regRead = cmdView;
         else if (a == `REG_PRODUCT_ID)
            regRead = PRODUCT_ID;
         else if (a == `REG_RESULT_HIGH)
            regRead = result_reg[15:8];
         else if (a == `REG_RESULT_LOW)
            regRead = result_reg[7:0];
         else if (inRange(a))
            regRead = genReg[a[4:0] - 5'h00];
         else
            regRead = 8'h00;
      end
   endfunction

   // The line is pulled only for a zero, so the first bit out is the inverted MSB.
   function pullMsb;
      input [7:0] a;
      reg   [7:0] b;
      begin
         b = regRead(a);
         pullMsb = ~b[7];
      end
   endfunction

   assign sdaOut = 1'b0;
   assign intOut = 1'b0;
   assign intOe = ready_reg;
   assign lowPowerOscEn = selfTimed_reg;

   // Both bus pins are asynchronous to ref_clk; the second stage alone feeds logic.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclSync <= {sclSync[0], sclIn};
         sdaSync <= {sdaSync[0], sdaIn};
         sclPrev <= scl;
         sdaPrev <= sda;
      end
   end

   // oversampled bit engine
   // At 3.4 MHz the bus clock gives about 29 samples per bit, so the two-stage
   // synchroniser delay still lands inside the data hold window.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         afterAck_reg <= ST_IDLE;
         bitCnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= `REG_FIRST;
         nack_reg <= 1'b0;
         sdaOe <= 1'b0;
         wrStrobe <= 1'b0;
         rdClear <= 1'b0;
         wrData <= 8'h00;
         wrAddr <= 8'h00;
      end else begin
         wrStrobe <= 1'b0;
         rdClear <= 1'b0;
         if (startCond) begin
            state_reg <= ST_ADDR;
            bitCnt_reg <= 4'h0;
            sdaOe <= 1'b0;
         end else if (stopCond) begin
            state_reg <= ST_IDLE;
            sdaOe <= 1'b0;
         end else begin
            case (state_reg)
               ST_ADDR, ST_RXREG, ST_RXDATA: begin
                  if (sclRise) begin
                     shift_reg <= {shift_reg[6:0], sda};
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end else if (sclFall && bitCnt_reg == 4'h8) begin
                     bitCnt_reg <= 4'h0;
                     state_reg <= ST_ACK;
                     sdaOe <= 1'b1;
                     if (state_reg == ST_ADDR) begin
                        if (shift_reg[7:1] != `TARGET_ADDR) begin
                           state_reg <= ST_IDLE;
                           sdaOe <= 1'b0;
                        end
                        afterAck_reg <= shift_reg[0] ? ST_TX : ST_RXREG;
                     end else if (state_reg == ST_RXREG) begin
                        ptr_reg <= shift_reg;
                        afterAck_reg <= ST_RXDATA;
                     end else begin
                        wrStrobe <= 1'b1;
                        wrData <= shift_reg;
                        wrAddr <= ptr_reg;
                        ptr_reg <= ptr_reg + 8'h01;
                        afterAck_reg <= ST_RXDATA;
                     end
                  end
               end
               ST_ACK: begin
                  if (sclFall) begin
                     state_reg <= afterAck_reg;
                     sdaOe <= 1'b0;
                     if (afterAck_reg == ST_TX) begin
                        tx_reg <= regRead(ptr_reg);
                        sdaOe <= pullMsb(ptr_reg);
                        rdClear <= (ptr_reg == `REG_RESULT_HIGH) ||
                                   (ptr_reg == `REG_RESULT_LOW);
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end
               end
               ST_TX: begin
                  if (sclRise) begin
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end else if (sclFall) begin
                     if (bitCnt_reg == 4'h8) begin
                        bitCnt_reg <= 4'h0;
                        sdaOe <= 1'b0;
                        state_reg <= ST_TXACK;
                     end else begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sdaOe <= ~tx_reg[6];
                     end
                  end
               end
               ST_TXACK: begin
                  if (sclRise) begin
                     nack_reg <= sda;
                  end else if (sclFall) begin
                     if (nack_reg) begin
                        state_reg <= ST_IDLE;
                     end else begin
                        state_reg <= ST_TX;
                        tx_reg <= regRead(ptr_reg);
                        sdaOe <= pullMsb(ptr_reg);
                        rdClear <= (ptr_reg == `REG_RESULT_HIGH) ||
                                   (ptr_reg == `REG_RESULT_LOW);
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end
               end
               default: begin
                  state_reg <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Register writes and the measurement sequencer share one process so that
   // a completing measurement and a host access never race on the same bit.
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         selfTimed_reg <= 1'b0;
         periodic_reg <= 1'b0;
         singleShot_reg <= 1'b0;
         ready_reg <= 1'b0;
         busy_reg <= 1'b0;
         shotPending_reg <= 1'b0;
         result_reg <= `RESULT_RESET;
         timer_reg <= 32'h0;
         measStart <= 1'b0;
         for (i = 0; i < 17; i = i + 1)
            genReg[i] <= `GEN_RESET;
      end else begin
         measStart <= 1'b0;
         if (wrStrobe && inRange(wrAddr) && wrAddr != `REG_PRODUCT_ID &&
             wrAddr != `REG_RESULT_HIGH && wrAddr != `REG_RESULT_LOW)
            genReg[wrAddr[4:0]] <= wrData;
         if (wrStrobe && wrAddr == `REG_COMMAND) begin
            selfTimed_reg <= wrData[`CMD_SELF_TIMED];
            periodic_reg <= wrData[`CMD_PERIODIC];
            if (wrData[`CMD_SINGLE_SHOT] && !wrData[`CMD_SELF_TIMED] && !selfTimed_reg)
               singleShot_reg <= 1'b1;
         end
         if (selfTimed_reg && periodic_reg) begin
            if (timer_reg >= MEAS_PERIOD - 32'h1) begin
               timer_reg <= 32'h0;
               if (!busy_reg) begin
                  measStart <= 1'b1;
                  busy_reg <= 1'b1;
                  shotPending_reg <= 1'b0;
               end
            end else begin
               timer_reg <= timer_reg + 32'h1;
            end
         end else begin
            timer_reg <= 32'h0;
            if (singleShot_reg && !selfTimed_reg && !busy_reg) begin
               measStart <= 1'b1;
               busy_reg <= 1'b1;
               shotPending_reg <= 1'b1;
            end
         end
         if (rdClear)
            ready_reg <= 1'b0;
         if (busy_reg && measDone) begin
            busy_reg <= 1'b0;
            result_reg <= measData;
            // new result sets ready, winning over a read clear
            ready_reg <= 1'b1;
            if (shotPending_reg)
               singleShot_reg <= 1'b0;
         end
      end
   end

endmodule

// [testbench/prox_port_sva.sv]
// Pin-level checks for the proximity sensor host port.
`timescale 1ns/1ps
module prox_port_sva (
   input wire ref_clk,
   input wire rst,
   input wire sclIn,
   input wire sdaOut,
   input wire sdaOe,
   input wire intOut,
   input wire intOe,
   input wire measStart,
   input wire measDone
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   reg busyReg;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) busyReg <= 1'b0;
      else if (measStart) busyReg <= 1'b1;
      else if (measDone) busyReg <= 1'b0;
   end
   a_sda_open: assert property (sdaOut == 1'b0)
      else $error("data pin driven high");
   a_int_open: assert property (intOut == 1'b0)
      else $error("interrupt pin driven high");
   a_ready_on_done: assert property (busyReg && measDone |=> intOe)
      else $error("ready not set after result");
   a_ready_cause: assert property ($rose(intOe) |-> $past(measDone))
      else $error("ready set without result");
   a_one_start: assert property (measStart |=> !measStart)
      else $error("start pulse too long");
   a_no_restart: assert property (busyReg |-> !measStart)
      else $error("start while busy");
   a_ack_scl_low: assert property ($rose(sdaOe) |-> !sclIn)
      else $error("data driven while clock high");
   a_sda_hold: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
      else $error("data changed while clock high");
   a_ready_clear: assert property ($fell(intOe) |-> !sclIn)
      else $error("ready cleared outside a read");
   c_start: cover property (measStart);
   c_clear: cover property ($fell(intOe));
   c_ack: cover property ($rose(sdaOe));
endmodule
bind proximity_sensor_host_port prox_port_sva u_sva (.ref_clk(ref_clk), .rst(rst),
   .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe),
   .measStart(measStart), .measDone(measDone));

// [testbench/i2c_host_model.sv]
// Behavioural bus host that reaches the sensor registers.
`timescale 1ns/1ps
module i2c_host_model (
   input  wire ref_clk,
   input  wire sdaOe,
   output reg  sclLine,
   output wire sdaLine
);
   reg sdaDrv = 1'b1;
   // Pull-up: the line is low while either party pulls it.
   assign sdaLine = sdaDrv & ~sdaOe;
   initial sclLine = 1'b1;
   task tick(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Start is cond(1,0), stop is cond(0,1): data moves while the clock is high.
   task cond(input reg a, input reg b);
      sclLine <= 1'b0;
      tick(5);
      sdaDrv <= a;
      tick(5);
      sclLine <= 1'b1;
      tick(5);
      sdaDrv <= b;
      tick(5);
   endtask
   task bitio(input reg b, output reg r);
      sclLine <= 1'b0;
      tick(5);
      sdaDrv <= b;
      tick(5);
      sclLine <= 1'b1;
      tick(5);
      #1 r = sdaLine;
      tick(5);
   endtask
   // A released ninth bit reads back low when the target acknowledges.
   task xbyte(input [7:0] d, output [7:0] q, output reg ack);
      reg r;
      for (int i = 7; i >= 0; i--) begin
         bitio(d[i], r);
         q[i] = r;
      end
      bitio(1'b1, r);
      ack = !r;
   endtask
   task xfer(input [6:0] dev, input [7:0] ra, input [7:0] wd, input reg wr,
             output [7:0] rd, output reg ok);
      reg [7:0] q;
      reg       a;
      cond(1'b1, 1'b0);
      xbyte({dev, 1'b0}, q, ok);
      xbyte(ra, q, a);
      ok = ok & a;
      if (wr) begin
         xbyte(wd, q, a);
         ok = ok & a;
      end
      cond(1'b0, 1'b1);
      if (!wr) begin
         cond(1'b1, 1'b0);
         xbyte({dev, 1'b1}, q, a);
         ok = ok & a;
         xbyte(8'hff, rd, a);
         cond(1'b0, 1'b1);
      end
   endtask
endmodule

// [testbench/proximity_sensor_host_port_bench.sv]
// Self-checking bench for the proximity sensor host port.
`timescale 1ns/1ps
module proximity_sensor_host_port_bench;
   reg         ref_clk = 1'b0;
   reg         rst = 1'b1;
   reg         measDone = 1'b0;
   reg  [15:0] measData = 16'hbe1f;
   wire        sclLine, sdaLine, sdaOut, sdaOe, intOut, intOe, measStart, lowPowerOscEn;
   reg  [7:0]  rd;
   reg         ok;
   integer     err_total = 0, n_tests = 0, nStarts = 0, dly = 0, n0;
   // Register, byte written, byte read back.
   reg  [23:0] rows [0:5] = '{24'h820505, 24'h90a5a5, 24'h81ff3c, 24'h87ff00,
                              24'h911100, 24'h8f5a5a};
   always #5 ref_clk = ~ref_clk;
   i2c_host_model HOST (.ref_clk(ref_clk), .sdaOe(sdaOe), .sclLine(sclLine),
      .sdaLine(sdaLine));
   proximity_sensor_host_port #(.MEAS_PERIOD(32'd50), .PRODUCT_ID(8'h3c)) DUT (
      .ref_clk(ref_clk), .rst(rst), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe), .measStart(measStart),
      .measDone(measDone), .measData(measData), .lowPowerOscEn(lowPowerOscEn));
   // Front end answers each request six cycles later.
   always @(posedge ref_clk) begin
      measDone <= (dly == 1);
      if (dly != 0) dly <= dly - 1;
      if (measStart) begin
         dly     <= 5;
         nStarts <= nStarts + 1;
      end
   end
   task chk(input [15:0] got, input [15:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      HOST.xfer(7'h13, a, d, 1'b1, rd, ok);
   endtask
   task rdr(input [7:0] a);
      HOST.xfer(7'h13, a, 8'h00, 1'b0, rd, ok);
   endtask
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      err_total = err_total + 1;
      end_of_test;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      HOST.tick(3);
      rdr(8'h80);
      chk(rd, 8'h80);
      chk({intOe, measStart, lowPowerOscEn}, 3'h0);
      for (int i = 0; i < 6; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         chk(ok, 1'b1);
         rdr(rows[i][23:16]);
         chk(rd, rows[i][7:0]);
      end
      HOST.xfer(7'h12, 8'h82, 8'hff, 1'b1, rd, ok);
      chk(ok, 1'b0);
      rdr(8'h82);
      chk(rd, 8'h05);
      wr(8'h80, 8'h08);
      chk(nStarts, 1);
      chk(intOe, 1'b1);
      rdr(8'h80);
      chk(rd, 8'ha0);
      rdr(8'h87);
      chk(rd, 8'hbe);
      chk(intOe, 1'b0);
      wr(8'h80, 8'h08);
      rdr(8'h88);
      chk(rd, 8'h1f);
      rdr(8'h80);
      chk(rd, 8'h80);
      wr(8'h80, 8'h01);
      chk(lowPowerOscEn, 1'b1);
      n0 = nStarts;
      wr(8'h80, 8'h09);
      rdr(8'h80);
      chk(rd, 8'h81);
      chk(nStarts - n0, 0);
      wr(8'h80, 8'h08);
      rdr(8'h80);
      chk(rd, 8'h80);
      chk(nStarts - n0, 0);
      wr(8'h80, 8'h01);
      wr(8'h80, 8'h03);
      rdr(8'h80);
      chk(rd, 8'ha3);
      chk(nStarts > n0, 1'b1);
      wr(8'h80, 8'h00);
      chk(lowPowerOscEn, 1'b0);
      rst <= 1'b1;
      HOST.tick(2);
      rst <= 1'b0;
      HOST.tick(3);
      rdr(8'h82);
      chk(rd, 8'h00);
      chk(intOe, 1'b0);
      end_of_test;
   end
endmodule
